/* core/evs_pkg.sv */
// package for the ev low-voltage supervisor: thresholds, timing, widths
// assumes a 250 MHz core clock; analog values arrive already digitised
package evs_pkg;
  // clock rate
  localparam int unsigned CLK_HZ = 250_000_000;
  // power-on initialisation time in milliseconds
  localparam int unsigned INIT_TIME_MS = 3000;
  localparam longint unsigned INIT_CYCLES =
    (longint'(CLK_HZ) * INIT_TIME_MS) / 1000;
  // aux battery threshold in millivolts (12.7 V)
  localparam logic [15:0] LOWBAT_MV_DEFAULT = 16'h319C;
  // state of charge floor in percent (25 %)
  localparam logic [6:0] SOC_FLOOR_PCT = 7'h19;
  // pump duty in percent (60 %)
  localparam logic [6:0] PUMP_DUTY_PCT_DEFAULT = 7'h3C;
  localparam logic [6:0] PWM_PERIOD_STEPS = 7'h64;
  // pwm step prescale: one step per this many clocks
  localparam int unsigned PWM_STEP_CYCLES = 250;
  // regen threshold in amps, magnitude of -35 A
  localparam logic [15:0] REGEN_AMPS_DEFAULT = 16'h0023;
  typedef enum logic [1:0] {
    EVS_ST_INIT = 2'b01,
    EVS_ST_RUN = 2'b10
  } evs_state_t;
endpackage

/* core/evs_supervisor.sv */
// ev 12 V supervisor: dc/dc, pump, fan, decel light, controller inhibits
// assumes all inputs synchronous to core_clk and already digitised
//
// Functional notes
// - dc/dc on: ignition, charging, or low-battery watchdog
// - watchdog activates at configured aux voltage threshold
// - watchdog blocked while state of charge below 25%
// - pump on driving or charging, isolated from ignition
// - pump pwm at configured duty, default 60%
// - fan follows bms request, driving and charging
// - fan request ignored when off and not charging
// - decel light: ignition on and regen at or beyond threshold
// - outputs valid only after 3 second initialisation
// - discharge and regen inhibit follow bms shutdown requests
// - brake/steering relay follows ignition
`timescale 1ns/1ps
`default_nettype none
module evs_supervisor #(
  parameter longint unsigned INIT_CYCLES = evs_pkg::INIT_CYCLES,
  parameter logic [15:0] LOWBAT_MV = evs_pkg::LOWBAT_MV_DEFAULT,
  parameter logic [6:0] PUMP_DUTY_PCT = evs_pkg::PUMP_DUTY_PCT_DEFAULT,
  parameter logic [15:0] REGEN_AMPS = evs_pkg::REGEN_AMPS_DEFAULT,
  parameter int unsigned PWM_STEP_CYCLES = evs_pkg::PWM_STEP_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ignition_on,
  input wire logic charging_mode,
  input wire logic [15:0] aux_batt_mv,
  input wire logic [6:0] soc_pct,
  input wire logic fan_request,
  input wire logic discharge_shutdown_req,
  input wire logic charge_shutdown_req,
  input wire logic signed [15:0] pack_current_a,
  output logic init_done,
  output logic dcdc_enable,
  output logic pump_enable,
  output logic pump_pwm,
  output logic fan_enable,
  output logic decel_light,
  output logic discharge_inhibit,
  output logic regen_inhibit,
  output logic brake_steer_relay
);

  // ==========================================================
  // input registers
  // ==========================================================
  logic ign_q;
  logic chg_q;
  logic fan_req_q;
  logic dis_req_q;
  logic chg_req_q;
  logic [15:0] aux_mv_q;
  logic [6:0] soc_q;
  logic signed [15:0] cur_q;
  // reads as a full battery so the watchdog stays quiet out of reset
  localparam logic [15:0] AUX_IDLE_MV = 16'hFFFF;

  // single-bit status lines
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ign_q <= 1'b0;
      chg_q <= 1'b0;
      fan_req_q <= 1'b0;
      dis_req_q <= 1'b0;
      chg_req_q <= 1'b0;
    end else begin
      ign_q <= ignition_on;
      chg_q <= charging_mode;
      fan_req_q <= fan_request;
      dis_req_q <= discharge_shutdown_req;
      chg_req_q <= charge_shutdown_req;
    end
  end

  // measured values, sampled every clock
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      aux_mv_q <= AUX_IDLE_MV;
      soc_q <= 7'h00;
      cur_q <= 16'sh0000;
    end else begin
      aux_mv_q <= aux_batt_mv;
      soc_q <= soc_pct;
      cur_q <= pack_current_a;
    end
  end

  // ==========================================================
  // initialisation timer
  // ==========================================================
  evs_pkg::evs_state_t state;
  logic [31:0] init_cnt;
  logic init_end;
  logic counting;
  localparam logic [31:0] INIT_LAST = 32'(INIT_CYCLES - 1);

  assign init_end = (init_cnt == INIT_LAST);
  assign counting = (state == evs_pkg::EVS_ST_INIT) && !init_end;

  // counter parks at its last value; only a reset starts it again
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      init_cnt <= 32'h0000_0000;
    end else if (counting) begin
      init_cnt <= init_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= evs_pkg::EVS_ST_INIT;
    end else begin
      case (state)
        evs_pkg::EVS_ST_INIT: begin
          if (init_end) begin
            state <= evs_pkg::EVS_ST_RUN;
          end
        end
        evs_pkg::EVS_ST_RUN: begin
          state <= evs_pkg::EVS_ST_RUN;
        end
        default: begin
          state <= evs_pkg::EVS_ST_INIT;
        end
      endcase
    end
  end

  logic run;
  assign run = (state == evs_pkg::EVS_ST_RUN);

  // ==========================================================
  // pump pwm: 100 steps per period
  // ==========================================================
  logic [15:0] step_cnt;
  logic step_en;
  logic [6:0] pwm_pos;
  localparam logic [15:0] STEP_LAST = 16'(PWM_STEP_CYCLES - 1);
  localparam logic [6:0] PWM_LAST = evs_pkg::PWM_PERIOD_STEPS - 7'h01;

  // prescaler runs from reset, so the pwm phase is free-running
  assign step_en = (step_cnt == STEP_LAST);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      step_cnt <= 16'h0000;
    end else if (step_en) begin
      step_cnt <= 16'h0000;
    end else begin
      step_cnt <= step_cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pwm_pos <= 7'h00;
    end else if (step_en) begin
      pwm_pos <= (pwm_pos == PWM_LAST) ? 7'h00 : pwm_pos + 7'h01;
    end
  end

  // ==========================================================
  // low-battery watchdog
  // ==========================================================
  logic watchdog_active;

  // watchdog triggers at or below the threshold voltage
  // no hysteresis: once the battery recovers the converter drops out
  assign watchdog_active = (aux_mv_q <= LOWBAT_MV)
    && (soc_q >= evs_pkg::SOC_FLOOR_PCT);

  // ==========================================================
  // control decisions
  // ==========================================================
  logic vehicle_live;
  logic regen_big;
  logic signed [16:0] regen_limit;

  assign vehicle_live = ign_q || chg_q;
  // regen current is negative; compare against the negated magnitude
  assign regen_limit = -$signed({1'b0, REGEN_AMPS});
  assign regen_big = ($signed({cur_q[15], cur_q}) <= regen_limit);

  // ==========================================================
  // next output values, all held low during init
  // ==========================================================
  logic next_init_done;
  logic next_dcdc_enable;
  logic next_pump_enable;
  logic next_pump_pwm;
  logic next_fan_enable;
  logic next_decel_light;
  logic next_discharge_inhibit;
  logic next_regen_inhibit;
  logic next_brake_steer_relay;

  always_comb begin
    next_init_done = 1'b0;
    next_dcdc_enable = 1'b0;
    next_pump_enable = 1'b0;
    next_pump_pwm = 1'b0;
    next_fan_enable = 1'b0;
    next_decel_light = 1'b0;
    next_discharge_inhibit = 1'b0;
    next_regen_inhibit = 1'b0;
    next_brake_steer_relay = 1'b0;

    if (run) begin
      next_init_done = 1'b1;
      next_dcdc_enable = ign_q || chg_q || watchdog_active;
      // pump has its own output so charging never drives ignition loads
      next_pump_enable = vehicle_live;
      next_pump_pwm = vehicle_live && (pwm_pos < PUMP_DUTY_PCT);
      next_fan_enable = fan_req_q && vehicle_live;
      next_decel_light = ign_q && regen_big;
      // inhibits pass straight through: the bms owns those decisions
      next_discharge_inhibit = dis_req_q;
      next_regen_inhibit = chg_req_q;
      next_brake_steer_relay = ign_q;
    end
  end

  // ==========================================================
  // output registers: no glitch ever reaches a relay driver
  // ==========================================================
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      init_done <= 1'b0;
    end else begin
      init_done <= next_init_done;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dcdc_enable <= 1'b0;
    end else begin
      dcdc_enable <= next_dcdc_enable;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pump_enable <= 1'b0;
    end else begin
      pump_enable <= next_pump_enable;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pump_pwm <= 1'b0;
    end else begin
      pump_pwm <= next_pump_pwm;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fan_enable <= 1'b0;
    end else begin
      fan_enable <= next_fan_enable;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      decel_light <= 1'b0;
    end else begin
      decel_light <= next_decel_light;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      discharge_inhibit <= 1'b0;
    end else begin
      discharge_inhibit <= next_discharge_inhibit;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      regen_inhibit <= 1'b0;
    end else begin
      regen_inhibit <= next_regen_inhibit;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      brake_steer_relay <= 1'b0;
    end else begin
      brake_steer_relay <= next_brake_steer_relay;
    end
  end

endmodule
`default_nettype wire

/* sim/evs_monitor.sv */
// checker for the ev supervisor, watching only its ports
// assumes two edges from input change to output once running
`timescale 1ns/1ps
`default_nettype none
module evs_monitor (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ignition_on,
  input wire logic charging_mode,
  input wire logic [15:0] aux_batt_mv,
  input wire logic [6:0] soc_pct,
  input wire logic fan_request,
  input wire logic discharge_shutdown_req,
  input wire logic charge_shutdown_req,
  input wire logic signed [15:0] pack_current_a,
  input wire logic init_done,
  input wire logic dcdc_enable,
  input wire logic pump_enable,
  input wire logic pump_pwm,
  input wire logic fan_enable,
  input wire logic decel_light,
  input wire logic discharge_inhibit,
  input wire logic regen_inhibit,
  input wire logic brake_steer_relay
);
  localparam logic signed [15:0] REGEN_MIN =
    -$signed(evs_pkg::REGEN_AMPS_DEFAULT);
  logic [1:0] on_q;
  logic [1:0] ign_q;
  logic [1:0] done_q;
  logic run;
  // ======================================
  // output relations
  // no reset: only read once run has held for two edges
  always_ff @(posedge core_clk) begin
    on_q <= {on_q[0], ignition_on | charging_mode};
    ign_q <= {ign_q[0], ignition_on};
    done_q <= {done_q[0], init_done};
  end
  // outputs settled from running inputs for two edges
  assign run = init_done && done_q[1];
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_dcdc_on_mode: assert property (
    run && on_q[1] |-> dcdc_enable) else $error("dcdc off in mode");
  chk_dcdc_watchdog: assert property (
    run && !on_q[1] |-> dcdc_enable == ($past(aux_batt_mv, 2) <=
    evs_pkg::LOWBAT_MV_DEFAULT && $past(soc_pct, 2) >=
    evs_pkg::SOC_FLOOR_PCT)) else $error("watchdog dcdc wrong");
  chk_pump_mode: assert property (
    run |-> pump_enable == on_q[1]) else $error("pump enable wrong");
  chk_pwm_idle: assert property (
    run && !on_q[1] |-> !pump_pwm) else $error("pwm while idle");
  chk_fan_gated: assert property (
    run |-> fan_enable == (on_q[1] && $past(fan_request, 2)))
    else $error("fan wrong");
  chk_decel_regen: assert property (
    run |-> decel_light == (ign_q[1] && $past(pack_current_a, 2) <=
    REGEN_MIN)) else $error("decel light wrong");
  chk_init_hold: assert property (
    init_done |=> init_done) else $error("init done dropped");
  chk_inhibit_follow: assert property (
    run |-> discharge_inhibit == $past(discharge_shutdown_req, 2) &&
    regen_inhibit == $past(charge_shutdown_req, 2))
    else $error("inhibit wrong");
  chk_relay_ignition: assert property (
    run |-> brake_steer_relay == ign_q[1]) else $error("relay wrong");
  chk_outputs_gated: assert property (
    !init_done |-> !(dcdc_enable | pump_enable | pump_pwm | fan_enable |
    decel_light | discharge_inhibit | regen_inhibit | brake_steer_relay))
    else $error("output before init");
endmodule
`default_nettype wire

/* sim/evs_bms_model.sv */
// battery management side: soc, current, fan and shutdown requests
// assumes the bench calls set just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module evs_bms_model (
  output logic [6:0] soc_pct,
  output logic fan_request,
  output logic discharge_shutdown_req,
  output logic charge_shutdown_req,
  output logic signed [15:0] pack_current_a
);
  // ======================================
  // request levels
  initial begin
    soc_pct = 7'h64;
    {fan_request, discharge_shutdown_req, charge_shutdown_req} = 3'h0;
    pack_current_a = 16'h0000;
  end
  task automatic set(input logic [6:0] s, input logic f, d, q,
      input logic [15:0] p);
    soc_pct <= s;
    fan_request <= f;
    discharge_shutdown_req <= d;
    charge_shutdown_req <= q;
    pack_current_a <= p;
  endtask
endmodule
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the ev supervisor, short init and pwm steps
// assumes evs_bms_model and evs_monitor are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int INIT = 20, STEP = 2;
  logic core_clk = 0, reset = 1, ignition_on = 0, charging_mode = 0;
  logic [15:0] aux_batt_mv = 16'hFFFF;
  logic [6:0] soc_pct;
  logic fan_request, discharge_shutdown_req, charge_shutdown_req;
  logic signed [15:0] pack_current_a;
  logic init_done, dcdc_enable, pump_enable, pump_pwm, fan_enable;
  logic decel_light, discharge_inhibit, regen_inhibit, brake_steer_relay;
  int fails = 0, tests_run = 0;
  wire logic [7:0] outs = {init_done, dcdc_enable, pump_enable, fan_enable,
    decel_light, discharge_inhibit, regen_inhibit, brake_steer_relay};
  always #2 core_clk = ~core_clk;
  evs_bms_model i_bms (.*);
  evs_supervisor #(.INIT_CYCLES(INIT), .PWM_STEP_CYCLES(STEP)) i_dut (.*);
  // ======================================
  // shared tasks
  task automatic final_report();
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, want);
    tests_run++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  function automatic logic [7:0] expect8();
    logic on;
    on = ignition_on | charging_mode;
    return {1'b1, on | (aux_batt_mv <= evs_pkg::LOWBAT_MV_DEFAULT &&
      soc_pct >= evs_pkg::SOC_FLOOR_PCT), on, fan_request & on,
      ignition_on && pack_current_a <= -$signed(evs_pkg::REGEN_AMPS_DEFAULT),
      discharge_shutdown_req, charge_shutdown_req, ignition_on};
  endfunction
  task automatic apply(input logic i, c, input logic [15:0] a,
      input logic [6:0] s, input logic f, d, q, input logic [15:0] p);
    @(posedge core_clk);
    ignition_on <= i;
    charging_mode <= c;
    aux_batt_mv <= a;
    i_bms.set(s, f, d, q, p);
    repeat (3) @(posedge core_clk);
    #1 check(outs, expect8());
  endtask
  // ======================================
  // scenarios
  task automatic t_init();
    int n;
    n = 0;
    ignition_on <= 1'b1;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (INIT - 2) @(posedge core_clk);
    #1 check(outs, 8'h00);
    while (init_done !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n == 40) begin
      fails++;
      final_report();
    end
    check(8'(n + INIT - 2), 8'(INIT + 1));
    check(outs, expect8());
    $display("init test done");
  endtask
  task automatic t_modes();
    for (int k = 0; k < 4; k++) apply(k[1], k[0], 16'hFFFF, 7'h64, 1'b1,
      1'b0, 1'b0, 16'h0000);
    apply(0, 0, 16'h319C, 7'h19, 1, 0, 0, 16'h0000);
    apply(0, 0, 16'h319D, 7'h19, 0, 1, 0, 16'h0000);
    apply(0, 0, 16'h319C, 7'h18, 0, 0, 1, 16'h0000);
    apply(1, 0, 16'hFFFF, 7'h64, 0, 0, 0, 16'hFFDD);
    apply(1, 0, 16'hFFFF, 7'h64, 0, 0, 0, 16'hFFDE);
    apply(0, 1, 16'hFFFF, 7'h64, 0, 0, 0, 16'hFFDD);
    $display("mode test done");
  endtask
  task automatic t_pwm();
    int n;
    n = 0;
    repeat (STEP * evs_pkg::PWM_PERIOD_STEPS) begin
      @(posedge core_clk);
      #1 n += int'(pump_pwm === 1'b1);
    end
    check(8'(n), 8'(STEP * evs_pkg::PUMP_DUTY_PCT_DEFAULT));
    $display("pwm test done");
  endtask
  initial begin
    t_init();
    t_modes();
    t_pwm();
    final_report();
  end
endmodule
bind evs_supervisor evs_monitor i_mon (.*);
`default_nettype wire
